//--- logic/acb_decoder.sv
// vendor ATA command block decoder and task-file sequencer
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RL1 - byte 0 must equal the configured signature to be a vendor block
// RL2 - byte 1 must hold 0x24 before the block is treated as ATA
// RL3 - any other block goes the normal mass-storage path untouched
// RL4 - host delivers exactly sixteen command block bytes
// RL5 - bit 7 flags identify data in the data phase
// RL6 - bit 6 picks UDMA transfers, otherwise PIO only
// RL7 - bit 5 takes DEV from byte 0x0B bit 4, else lun startup value
// RL8 - bit 4 clear halts data on device error, set continues
// RL9 - bit 3 clear halts data on phase error, set continues
// RL10 - host keeps both error overrides clear on task-file-only reads
// RL11 - bit 2 clear polls alternate status until BSY is zero first
// RL12 - bit 1 puts device selection before or after register writes
// RL13 - bit 0 reads only selected registers, zero for others, no command
// RL14 - bit 0 clear runs the command and any data transfer
// RL15 - host asks for eight bytes on a task-file-only read
// RL16 - result bytes run alternate status through command status
// RL17 - byte 3 selects registers, accessed from bit 0 up to bit 7
// RL18 - byte 4 block size must be zero or a power of two up to 128
// RL19 - all action bits are latched before any register access
module acb_decoder (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic TF_REQ,
  output logic TF_WE,
  output logic [2:0] TF_SEL,
  output logic [7:0] TF_WDATA,
  input wire logic TF_ACK,
  input wire logic [7:0] TF_RDATA,
  output logic XFER_START,
  output logic XFER_ACTIVE,
  output logic XFER_ABORT,
  output logic IDENTIFY_DATA,
  output logic ULTRA_DMA,
  output logic [8:0] BLOCK_SECTORS,
  input wire logic XFER_DONE,
  input wire logic DEV_ERR,
  input wire logic PHASE_ERR,
  output logic NORMAL_PATH
);
  // ==========================================================================
  // storage and decode nets
  logic [7:0] cb_ff [acb_pkg::CB_BYTES];
  logic [7:0] res_ff [8];
  logic [7:0] sig_ff, rsel_ff, wdat_ff, rdata_ff, bcnt, devhead;
  logic [2:0] idx_ff, sel_ff;
  logic [8:0] sect_ff;
  acb_pkg::acb_action_t act_ff, act_new;
  acb_pkg::acb_state_t state_ff, after_poll;
  logic lun_dev_ff, req_ff, we_ff;
  logic xstart_ff, xact_ff, xabort_ff, ident_ff, udma_ff, normal_ff;
  logic done_ff, vendor_ff, fail_ff, derr_ff, perr_ff;
  logic go, clr_wr, blk_legal, sig_match, sel_hit, acked;
  // ==========================================================================
  // decode helpers
  assign go = WR && ADDR == acb_pkg::REG_CTRL && WDATA[acb_pkg::CTRL_GO];
  assign clr_wr = WR && ADDR == acb_pkg::REG_STATUS;
  assign sig_match = cb_ff[acb_pkg::CB_SIG] == sig_ff && // RL1
    cb_ff[acb_pkg::CB_SUB] == acb_pkg::SUB_ATA; // RL2
  assign bcnt = cb_ff[acb_pkg::CB_BCNT];
  assign blk_legal = (bcnt & (bcnt - 8'h01)) == 8'h00; // RL18
  assign act_new = acb_pkg::acb_action_t'(cb_ff[acb_pkg::CB_ACT]);
  assign sel_hit = rsel_ff[idx_ff]; // RL17
  assign acked = req_ff && TF_ACK;
  // device bit either from the block or from the lun's startup value
  assign devhead = {cb_ff[acb_pkg::CB_DEVHEAD][7:5],
    act_ff.device_bit_source ? cb_ff[acb_pkg::CB_DEVHEAD][acb_pkg::DEV_BIT]
                             : lun_dev_ff, // RL7
    cb_ff[acb_pkg::CB_DEVHEAD][3:0]};
  // where to go once the busy wait is over or skipped
  assign after_poll = act_ff.register_read_only ? acb_pkg::S_READ
    : (act_ff.select_after_command ? acb_pkg::S_WRITE
                                   : acb_pkg::S_SEL_PRE); // RL12 RL13
  // ==========================================================================
  // software-written bytes; block bytes are frozen while a block runs
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      cb_ff <= '{default: acb_pkg::BYTE_RESET};
      sig_ff <= acb_pkg::SIG_RESET;
      lun_dev_ff <= 1'b0;
    end else if (WR) begin
      if (ADDR <= acb_pkg::REG_CB_LAST && state_ff == acb_pkg::S_IDLE) begin
        cb_ff[ADDR[3:0]] <= WDATA; // RL4
      end
      if (ADDR == acb_pkg::REG_SIG) begin
        sig_ff <= WDATA;
      end
      if (ADDR == acb_pkg::REG_LUN_DEV) begin
        lun_dev_ff <= WDATA[0];
      end
    end
  end
  // ==========================================================================
  // read data, one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge MCLK) begin
    if (SRST || !RD) begin
      rdata_ff <= 8'h00;
    end else if (ADDR <= acb_pkg::REG_CB_LAST) begin
      rdata_ff <= cb_ff[ADDR[3:0]];
    end else if (ADDR[7:3] == acb_pkg::REG_RES_BASE[7:3]) begin
      rdata_ff <= res_ff[ADDR[2:0]];
    end else if (ADDR == acb_pkg::REG_SIG) begin
      rdata_ff <= sig_ff;
    end else if (ADDR == acb_pkg::REG_LUN_DEV) begin
      rdata_ff <= {7'h00, lun_dev_ff};
    end else if (ADDR == acb_pkg::REG_STATUS) begin
      rdata_ff <= {2'h0, perr_ff, derr_ff, fail_ff, vendor_ff, done_ff,
                   state_ff != acb_pkg::S_IDLE};
    end else begin
      rdata_ff <= 8'h00;
    end
  end
  // ==========================================================================
  // sequencer: decode, busy wait, selection, writes, reads and data phase
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      state_ff <= acb_pkg::S_IDLE;
      act_ff <= '0;
      rsel_ff <= 8'h00;
      idx_ff <= 3'h0;
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      sel_ff <= 3'h0;
      wdat_ff <= 8'h00;
      xstart_ff <= 1'b0;
      xact_ff <= 1'b0;
      xabort_ff <= 1'b0;
      ident_ff <= 1'b0;
      udma_ff <= 1'b0;
      sect_ff <= 9'h000;
      normal_ff <= 1'b0;
      done_ff <= 1'b0;
      vendor_ff <= 1'b0;
      fail_ff <= 1'b0;
      derr_ff <= 1'b0;
      perr_ff <= 1'b0;
      res_ff <= '{default: 8'h00};
    end else begin
      xstart_ff <= 1'b0;
      xabort_ff <= 1'b0;
      normal_ff <= 1'b0;
      // software clear first so that a hardware set in this cycle wins
      if (clr_wr) begin
        done_ff <= done_ff & ~WDATA[acb_pkg::ST_DONE];
        vendor_ff <= vendor_ff & ~WDATA[acb_pkg::ST_VENDOR];
        fail_ff <= fail_ff & ~WDATA[acb_pkg::ST_FAIL];
        derr_ff <= derr_ff & ~WDATA[acb_pkg::ST_DERR];
        perr_ff <= perr_ff & ~WDATA[acb_pkg::ST_PERR];
      end
      unique case (state_ff)
        acb_pkg::S_IDLE: begin
          if (go) begin
            state_ff <= acb_pkg::S_DECODE;
          end
        end
        acb_pkg::S_DECODE: begin
          idx_ff <= 3'h0;
          if (!sig_match) begin
            normal_ff <= 1'b1; // RL3
            done_ff <= 1'b1;
            state_ff <= acb_pkg::S_IDLE;
          end else if (!blk_legal) begin
            vendor_ff <= 1'b1;
            fail_ff <= 1'b1; // RL18
            done_ff <= 1'b1;
            state_ff <= acb_pkg::S_IDLE;
          end else begin
            // every option is latched here, ahead of any access
            act_ff <= act_new; // RL19
            rsel_ff <= cb_ff[acb_pkg::CB_RSEL];
            ident_ff <= act_new.identify_data_flag; // RL5
            udma_ff <= act_new.ultra_dma_enable; // RL6
            sect_ff <= bcnt == 8'h00 ? acb_pkg::SECT_256 : {1'b0, bcnt};
            vendor_ff <= 1'b1;
            state_ff <= acb_pkg::S_POLL;
          end
        end
        acb_pkg::S_POLL: begin
          if (act_ff.skip_busy_poll) begin
            state_ff <= after_poll; // RL11
          end else if (!req_ff) begin
            req_ff <= 1'b1;
            we_ff <= 1'b0;
            sel_ff <= acb_pkg::TF_ALTERNATE_STATUS_REG;
          end else if (TF_ACK) begin
            req_ff <= 1'b0;
            if (!TF_RDATA[acb_pkg::TF_BSY_BIT]) begin
              state_ff <= after_poll; // RL11
            end
          end
        end
        acb_pkg::S_SEL_PRE, acb_pkg::S_SEL_POST: begin
          if (!req_ff) begin
            req_ff <= 1'b1;
            we_ff <= 1'b1;
            sel_ff <= acb_pkg::TF_DEVHEAD;
            wdat_ff <= devhead; // RL7
          end else if (TF_ACK) begin
            req_ff <= 1'b0;
            idx_ff <= 3'h0;
            if (state_ff == acb_pkg::S_SEL_PRE) begin
              state_ff <= acb_pkg::S_WRITE; // RL12
            end else begin
              state_ff <= acb_pkg::S_XFER;
              xstart_ff <= 1'b1; // RL14
              xact_ff <= 1'b1;
            end
          end
        end
        acb_pkg::S_WRITE: begin
          // selected registers from index 0 up; selection is its own step
          if (!req_ff && sel_hit && idx_ff != acb_pkg::TF_DEVHEAD) begin
            req_ff <= 1'b1;
            we_ff <= 1'b1;
            sel_ff <= idx_ff;
            wdat_ff <= cb_ff[acb_pkg::CB_TF_WR + int'(idx_ff)];
          end else if (!req_ff || TF_ACK) begin
            req_ff <= 1'b0;
            idx_ff <= idx_ff + 3'h1; // RL17
            if (idx_ff == acb_pkg::TF_LAST) begin
              if (act_ff.select_after_command) begin
                state_ff <= acb_pkg::S_SEL_POST; // RL12
              end else begin
                state_ff <= acb_pkg::S_XFER;
                xstart_ff <= 1'b1; // RL14
                xact_ff <= 1'b1;
              end
            end
          end
        end
        acb_pkg::S_READ: begin
          // only reads, no command goes out; unselected bytes are zero
          if (!req_ff && sel_hit) begin
            req_ff <= 1'b1;
            we_ff <= 1'b0;
            sel_ff <= idx_ff;
          end else if (!req_ff || TF_ACK) begin
            req_ff <= 1'b0;
            res_ff[idx_ff] <= req_ff ? TF_RDATA : 8'h00; // RL13 RL16
            idx_ff <= idx_ff + 3'h1; // RL17
            if (idx_ff == acb_pkg::TF_LAST) begin
              done_ff <= 1'b1;
              state_ff <= acb_pkg::S_IDLE;
            end
          end
        end
        acb_pkg::S_XFER: begin
          if (DEV_ERR) begin
            derr_ff <= 1'b1;
          end
          if (PHASE_ERR) begin
            perr_ff <= 1'b1;
          end
          // an unmasked error ends the data phase at once
          if ((DEV_ERR && !act_ff.device_error_continue) // RL8
              || (PHASE_ERR && !act_ff.phase_error_continue)) begin // RL9
            xact_ff <= 1'b0;
            xabort_ff <= 1'b1;
            fail_ff <= 1'b1;
            done_ff <= 1'b1;
            state_ff <= acb_pkg::S_IDLE;
          end else if (XFER_DONE) begin
            xact_ff <= 1'b0;
            done_ff <= 1'b1;
            state_ff <= acb_pkg::S_IDLE;
          end
        end
      endcase
    end
  end
  // ==========================================================================
  // outputs straight from flip-flops
  assign RDATA = rdata_ff;
  assign TF_REQ = req_ff;
  assign TF_WE = we_ff;
  assign TF_SEL = sel_ff;
  assign TF_WDATA = wdat_ff;
  assign XFER_START = xstart_ff;
  assign XFER_ACTIVE = xact_ff;
  assign XFER_ABORT = xabort_ff;
  assign IDENTIFY_DATA = ident_ff;
  assign ULTRA_DMA = udma_ff;
  assign BLOCK_SECTORS = sect_ff;
  assign NORMAL_PATH = normal_ff;
  // ==========================================================================
  // checks
  default clocking cb_chk @(posedge MCLK); endclocking
  default disable iff (SRST);
  sequence s_decoding;
    state_ff == acb_pkg::S_DECODE;
  endsequence
  sequence s_good_block;
    s_decoding ##0 sig_match && blk_legal;
  endsequence
  a_foreign_block: assert property (s_decoding ##0 !sig_match // RL1
    |=> NORMAL_PATH && state_ff == acb_pkg::S_IDLE && !TF_REQ)
    else $error("foreign block did not take the normal path");
  a_sub_command: assert property (NORMAL_PATH // RL2
    |-> $past(cb_ff[acb_pkg::CB_SUB]) != acb_pkg::SUB_ATA
        || $past(cb_ff[acb_pkg::CB_SIG]) != $past(sig_ff))
    else $error("normal path taken for a matching block");
  a_bad_count: assert property (s_decoding ##0 sig_match && !blk_legal // RL18
    |=> fail_ff && done_ff && state_ff == acb_pkg::S_IDLE)
    else $error("illegal block size not failed");
  a_busy_wait: assert property (state_ff == acb_pkg::S_POLL // RL11
    && acked && TF_RDATA[acb_pkg::TF_BSY_BIT] |=> state_ff == acb_pkg::S_POLL)
    else $error("left busy wait while busy");
  a_skip_poll: assert property (s_good_block ##1 act_ff.skip_busy_poll // RL11
    |=> state_ff != acb_pkg::S_POLL && !TF_REQ)
    else $error("busy wait not skipped");
  a_select_first: assert property (state_ff == acb_pkg::S_SEL_PRE // RL12
    && acked |=> state_ff == acb_pkg::S_WRITE && idx_ff == 3'h0)
    else $error("writes did not follow device selection");
  a_read_only: assert property (state_ff == acb_pkg::S_READ // RL13
    |-> !XFER_ACTIVE && !(TF_REQ && TF_WE))
    else $error("task-file read issued a write or transfer");
  a_unselected_zero: assert property (state_ff == acb_pkg::S_READ // RL13
    && !req_ff && !sel_hit |=> res_ff[$past(idx_ff)] == 8'h00)
    else $error("unselected register not zero");
  a_dev_halt: assert property (state_ff == acb_pkg::S_XFER && DEV_ERR // RL8
    && !act_ff.device_error_continue |=> !XFER_ACTIVE && XFER_ABORT)
    else $error("device error did not halt the data phase");
  a_phase_halt: assert property (state_ff == acb_pkg::S_XFER // RL9
    && PHASE_ERR && !act_ff.phase_error_continue
    |=> !XFER_ACTIVE && XFER_ABORT ##1 !XFER_ABORT)
    else $error("phase error did not halt the data phase");
  a_action_held: assert property (state_ff != acb_pkg::S_IDLE // RL19
    && state_ff != acb_pkg::S_DECODE |=> $stable(act_ff))
    else $error("action bits changed mid block");
endmodule : acb_decoder
`default_nettype wire

//--- logic/acb_pkg.sv
// package for the vendor ATA command block decoder: offsets, fields, types
package acb_pkg;

  // ==========================================================================
  // register map on the plain software port
  localparam logic [7:0] REG_CB_BASE = 8'h00; // command block bytes 0..15
  localparam logic [7:0] REG_CB_LAST = 8'h0F;
  localparam logic [7:0] REG_SIG = 8'h10;     // expected block signature
  localparam logic [7:0] REG_CTRL = 8'h11;    // bit 0 starts the decoder
  localparam logic [7:0] REG_STATUS = 8'h12;  // state flags, W1C bits 1..5
  localparam logic [7:0] REG_LUN_DEV = 8'h13; // startup device bit of the lun
  localparam logic [7:0] REG_RES_BASE = 8'h18; // task-file read result 0..7
  localparam logic [7:0] REG_RES_LAST = 8'h1F;

  // ==========================================================================
  // reset values
  localparam logic [7:0] SIG_RESET = 8'h00; // arbitrary, loaded by software
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ==========================================================================
  // command block byte positions and codes
  localparam int CB_SIG = 0;
  localparam int CB_SUB = 1;
  localparam int CB_ACT = 2;
  localparam int CB_RSEL = 3;
  localparam int CB_BCNT = 4;
  localparam int CB_TF_WR = 5;    // first task-file write byte
  localparam int CB_DEVHEAD = 11;
  localparam int CB_BYTES = 16;
  localparam logic [7:0] SUB_ATA = 8'h24;
  localparam logic [8:0] SECT_256 = 9'h100;

  // ==========================================================================
  // task-file register indices and bits
  localparam logic [2:0] TF_ALTERNATE_STATUS_REG = 3'h0; // 0x3F6
  localparam logic [2:0] TF_DEVHEAD = 3'h6; // 0x1F6
  localparam logic [2:0] TF_LAST = 3'h7;    // 0x1F7
  localparam int TF_BSY_BIT = 7;
  localparam int DEV_BIT = 4;

  // ==========================================================================
  // status and control register bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_VENDOR = 2;
  localparam int ST_FAIL = 3;
  localparam int ST_DERR = 4;
  localparam int ST_PERR = 5;
  localparam int CTRL_GO = 0;

  // action select byte, bit 7 down to bit 0
  typedef struct packed {
    logic identify_data_flag;
    logic ultra_dma_enable;
    logic device_bit_source;
    logic device_error_continue;
    logic phase_error_continue;
    logic skip_busy_poll;
    logic select_after_command;
    logic register_read_only;
  } acb_action_t;

  typedef enum {
    S_IDLE, S_DECODE, S_POLL, S_SEL_PRE, S_WRITE, S_SEL_POST, S_READ, S_XFER
  } acb_state_t;

endpackage : acb_pkg

//--- verif/acb_tf_model.sv
// behavioural model of the attached drive's task-file registers
`timescale 1ns/1ps
`default_nettype none
module acb_tf_model (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic TF_REQ,
  input wire logic TF_WE,
  input wire logic [2:0] TF_SEL,
  input wire logic [7:0] TF_WDATA,
  output logic TF_ACK,
  output logic [7:0] TF_RDATA
);
  // ==========================================================================
  // register file, slow answer and a short busy spell after reset
  logic [7:0] regs_ff [8];
  logic [1:0] wait_ff;
  logic [1:0] busy_ff;
  logic [7:0] last_ff;
  logic [7:0] rval;

  // alternate status shows busy for the first two polls only
  assign rval = (TF_SEL == 3'h0) ? {busy_ff != 2'h0, 7'h50} : regs_ff[TF_SEL];
  // released bus shows the inverse so a stale byte never passes
  assign TF_RDATA = TF_ACK ? last_ff : ~last_ff;

  // each access answered three cycles after the request rises
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      wait_ff <= 2'h0;
      busy_ff <= 2'h2;
      TF_ACK <= 1'b0;
      last_ff <= 8'h00;
      for (int i = 0; i < 8; i++) regs_ff[i] <= 8'h10 + 8'(i);
    end else begin
      TF_ACK <= 1'b0;
      if (TF_REQ && !TF_ACK) begin
        wait_ff <= wait_ff + 2'h1;
        if (wait_ff == 2'h2) begin
          TF_ACK <= 1'b1;
          wait_ff <= 2'h0;
          last_ff <= rval;
          if (TF_WE) regs_ff[TF_SEL] <= TF_WDATA;
          else if (TF_SEL == 3'h0 && busy_ff != 2'h0) busy_ff <= busy_ff - 2'h1;
        end
      end
    end
  end
endmodule : acb_tf_model
`default_nettype wire

//--- verif/ata_command_block_decoder_tb.sv
// self-checking bench for the vendor command block decoder
`timescale 1ns/1ps
`default_nettype none
module ata_command_block_decoder_tb;
  // ==========================================================================
  // signals
  logic MCLK = 1'b0;
  logic SRST = 1'b1;
  logic [7:0] ADDR = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic XFER_DONE = 1'b0;
  logic DEV_ERR = 1'b0;
  logic PHASE_ERR = 1'b0;
  logic [7:0] RDATA, TF_WDATA, TF_RDATA, rv;
  logic TF_REQ, TF_WE, TF_ACK, XFER_START, XFER_ACTIVE, XFER_ABORT;
  logic IDENTIFY_DATA, ULTRA_DMA, NORMAL_PATH;
  logic [2:0] TF_SEL;
  logic [8:0] BLOCK_SECTORS;
  logic [11:0] log_q [$];
  logic [1:0] errsel = 2'h0;
  logic [2:0] xcnt = 3'h0;
  int fail_count = 0;
  int check_count = 0;
  int np_cnt = 0;
  int ab_cnt = 0;
  int xs_cnt = 0;

  always #2.5 MCLK = ~MCLK;

  acb_decoder u_acb_decoder (.MCLK(MCLK), .SRST(SRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TF_REQ(TF_REQ),
    .TF_WE(TF_WE), .TF_SEL(TF_SEL), .TF_WDATA(TF_WDATA), .TF_ACK(TF_ACK),
    .TF_RDATA(TF_RDATA), .XFER_START(XFER_START),
    .XFER_ACTIVE(XFER_ACTIVE), .XFER_ABORT(XFER_ABORT),
    .IDENTIFY_DATA(IDENTIFY_DATA), .ULTRA_DMA(ULTRA_DMA),
    .BLOCK_SECTORS(BLOCK_SECTORS), .XFER_DONE(XFER_DONE),
    .DEV_ERR(DEV_ERR), .PHASE_ERR(PHASE_ERR), .NORMAL_PATH(NORMAL_PATH));

  acb_tf_model u_acb_tf_model (.MCLK(MCLK), .SRST(SRST), .TF_REQ(TF_REQ),
    .TF_WE(TF_WE), .TF_SEL(TF_SEL), .TF_WDATA(TF_WDATA), .TF_ACK(TF_ACK),
    .TF_RDATA(TF_RDATA));

  // ==========================================================================
  // data phase partner: errors at beat 2, completion at beat 5
  always @(posedge MCLK) begin
    xcnt <= (SRST || !XFER_ACTIVE) ? 3'h0 : xcnt + 3'h1;
    DEV_ERR <= !SRST && XFER_ACTIVE && xcnt == 3'h2 && errsel[0];
    PHASE_ERR <= !SRST && XFER_ACTIVE && xcnt == 3'h2 && errsel[1];
    XFER_DONE <= !SRST && XFER_ACTIVE && xcnt == 3'h5;
  end

  // monitor: log every answered access as {write, index, byte}
  always @(posedge MCLK) begin
    if (NORMAL_PATH === 1'b1) np_cnt++;
    if (XFER_ABORT === 1'b1) ab_cnt++;
    if (XFER_START === 1'b1) xs_cnt++;
    if (TF_REQ === 1'b1 && TF_ACK === 1'b1)
      log_q.push_back({TF_WE, TF_SEL, TF_WE ? TF_WDATA : TF_RDATA});
  end

  // ==========================================================================
  // bus tasks and compares
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr

  // read data is looked at mid-cycle, in its one valid cycle
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    @(negedge MCLK);
    d = RDATA;
  endtask : rd

  task chk(input logic [11:0] g, input logic [11:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task chkq(input logic [11:0] e [$]);
    chk(12'(log_q.size()), 12'(e.size()));
    foreach (e[i]) chk(log_q[i], e[i]);
  endtask : chkq

  task summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // sixteen bytes always sent whole; other bytes left zero
  task blk(input logic [7:0] act, rsel, cnt, b7, b11, b12);
    for (int i = 0; i < acb_pkg::CB_BYTES; i++)
      wr(acb_pkg::REG_CB_BASE + 8'(i), i == 0 ? 8'h3C : i == 1 ?
        acb_pkg::SUB_ATA : i == 2 ? act : i == 3 ? rsel : i == 4 ? cnt :
        i == 7 ? b7 : i == 11 ? b11 : i == 12 ? b12 : 8'h00);
  endtask : blk

  // clear flags, start, then poll busy under a bound
  task go;
    int i;
    wr(acb_pkg::REG_STATUS, 8'h3E);
    log_q.delete();
    wr(acb_pkg::REG_CTRL, 8'h01);
    for (i = 0; i < 500; i++) begin
      rd(acb_pkg::REG_STATUS, rv);
      if (rv[acb_pkg::ST_BUSY] === 1'b0) break;
    end
    if (i == 500) begin
      fail_count++;
      summarize();
    end
  endtask : go

  // ==========================================================================
  // main sequence
  logic [7:0] ta [4] = '{8'h14, 8'h14, 8'h0C, 8'h0C};
  logic [1:0] te [4] = '{2'h1, 2'h2, 2'h2, 2'h1};
  logic [7:0] ts [4] = '{8'h16, 8'h2E, 8'h26, 8'h1E};
  int tab [4] = '{1, 2, 2, 3};

  initial begin
    repeat (10) @(posedge MCLK);
    SRST <= 1'b0;
    rd(acb_pkg::REG_SIG, rv);
    chk(rv, acb_pkg::SIG_RESET);
    rd(acb_pkg::REG_STATUS, rv);
    chk(rv, 8'h00);
    rd(8'h40, rv);
    chk(rv, 8'h00);
    wr(acb_pkg::REG_SIG, 8'h3C); // arbitrary signature
    wr(acb_pkg::REG_LUN_DEV, 8'h01);
    $display("test reset done");
    // register read only, busy polling, registers 0 and 7
    blk(8'h01, 8'h81, 8'h01, 8'h00, 8'h00, 8'h00);
    go();
    chkq('{12'h0D0, 12'h0D0, 12'h050, 12'h050, 12'h717});
    for (int i = 0; i < 8; i++) begin
      rd(acb_pkg::REG_RES_BASE + 8'(i), rv);
      chk(rv, i == 0 ? 8'h50 : i == 7 ? 8'h17 : 8'h00);
    end
    rd(acb_pkg::REG_STATUS, rv);
    chk(rv, 8'h06);
    chk(12'(xs_cnt), 12'h000);
    $display("test read only done");
    // select before writes, lun device bit, pio, count 0
    blk(8'h04, 8'h84, 8'h00, 8'h22, 8'hA0, 8'hEC);
    go();
    chkq('{12'hEB0, 12'hA22, 12'hFEC});
    chk(BLOCK_SECTORS, acb_pkg::SECT_256);
    chk({ULTRA_DMA, IDENTIFY_DATA}, 2'h0);
    rd(acb_pkg::REG_STATUS, rv);
    chk(rv, 8'h06);
    chk(12'(xs_cnt), 12'h001);
    // select after writes, block device bit, udma, device error halts
    errsel = 2'h1;
    blk(8'hE6, 8'h80, 8'h80, 8'h00, 8'hE0, 8'hA1);
    go();
    chkq('{12'hFA1, 12'hEE0});
    chk(BLOCK_SECTORS, 9'h080);
    chk({ULTRA_DMA, IDENTIFY_DATA}, 2'h3);
    rd(acb_pkg::REG_STATUS, rv);
    chk(rv, 8'h1E);
    chk(12'(ab_cnt), 12'h001);
    chk(12'(xs_cnt), 12'h002);
    $display("test execute done");
    // error override table
    for (int k = 0; k < 4; k++) begin
      errsel = te[k];
      blk(ta[k], 8'h00, 8'h01, 8'h00, 8'hA0, 8'h00);
      go();
      rd(acb_pkg::REG_STATUS, rv);
      chk(rv, ts[k]);
      chk(12'(xs_cnt), 12'(k + 3));
      chk(12'(ab_cnt), 12'(tab[k]));
    end
    $display("test overrides done");
    // illegal block count: fail before any access
    errsel = 2'h0;
    blk(8'h04, 8'h80, 8'h03, 8'h00, 8'hA0, 8'h00);
    go();
    chk(12'(log_q.size()), 12'h000);
    rd(acb_pkg::REG_STATUS, rv);
    chk(rv, 8'h0E);
    // foreign blocks: bad signature, then bad sub-command
    for (int k = 0; k < 2; k++) begin
      blk(8'h04, 8'h80, 8'h01, 8'h00, 8'hA0, 8'h00);
      wr(acb_pkg::REG_CB_BASE + 8'(k), 8'h5A);
      go();
      chk(12'(log_q.size()), 12'h000);
      rd(acb_pkg::REG_STATUS, rv);
      chk(rv, 8'h02);
      chk(12'(xs_cnt), 12'h006);
      chk(12'(np_cnt), 12'(k + 1));
    end
    $display("test foreign done");
    summarize();
  end
endmodule : ata_command_block_decoder_tb
`default_nettype wire
